//--- oc_ot_pkg.sv
/*
 * Shared constants for the per-rail overcurrent response and
 * over-temperature limit block: command codes, field positions,
 * reset values, retry timing and the rail state encoding.
 * Assumes a 50 MHz core clock and two paged rails.
 */
package oc_ot_pkg;
    // Paged command codes
    localparam logic [7:0] CMD_OC_RESP = 8'h47;
    localparam logic [7:0] CMD_OT_LIMIT = 8'h4F;
    // Reset values
    localparam logic [7:0] OC_RESP_RESET = 8'hC4;
    localparam logic [15:0] OT_LIMIT_RESET = 16'h007D;
    // Highest supported threshold, one count per degree
    localparam logic [15:0] OT_LIMIT_MAX = 16'h0096;
    // Clear hysteresis below the threshold, in degrees
    localparam logic [16:0] OT_HYST = 17'h00005;
    // Response byte field positions
    localparam int RESP_HI = 7;
    localparam int RESP_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int DELAY_HI = 2;
    localparam int DELAY_LO = 0;
    // Field codes
    localparam logic [1:0] RESP_CONTINUE = 2'h0;
    localparam logic [1:0] RESP_SHUTDOWN = 2'h3;
    localparam logic [2:0] RETRY_LATCH = 3'h0;
    localparam logic [2:0] RETRY_CONT = 3'h7;
    localparam logic [2:0] DELAY_ZERO = 3'h0;
    localparam logic [2:0] DELAY_LONG = 3'h7;
    // Retry timing
    localparam int CLK_HZ = 50_000_000;
    localparam int RETRY_STEP_MS = 25;
    localparam int RETRY_LONG_MS = 175;
    localparam int RETRY_STEP_CYC = RETRY_STEP_MS * (CLK_HZ / 1000);
    localparam int RETRY_LONG_CYC = RETRY_LONG_MS * (CLK_HZ / 1000);
    localparam int CNT_W = 24;
    localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
    // Number of pages
    localparam int NUM_RAILS = 2;
    // Rail supervision states
    typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_LATCHED, ST_WAIT} rail_state_e;
endpackage : oc_ot_pkg

//--- oc_fault_response_ot_limit.sv
/*
 * Per-rail overcurrent/undercurrent fault response and over-temperature
 * threshold, with paged command access and an active-low alert output.
 * Assumes detectors, temperature and operation inputs come from logic on
 * core_clk; control pin and bias-good come from pins and are synchronised.
 */
// Behaviour
// - One response serves overcurrent and undercurrent
// - Bits 7:6: 00 continue, 11 shut down
// - Fault pulls alert low, sets status flag
// - Retry 000 latches rail off until restart
// - Retry 111 restarts forever, spaced by delay
// - Off command, bias loss, other fault stop retries
// - Delay 0ms, 25ms per count, 175ms
// - Response byte per page, resets to C4h
// - Per-rail 16-bit threshold, one degree per count
// - Threshold supports zero to 150 degrees
// - Threshold resets to 007Dh
// - Over-temperature clears 5 degrees below threshold
`timescale 1ns/1ps
module oc_fault_response_ot_limit #(
    parameter int RETRY_STEP_CYC = oc_ot_pkg::RETRY_STEP_CYC,
    parameter int RETRY_LONG_CYC = oc_ot_pkg::RETRY_LONG_CYC
) (
    input wire logic core_clk,
    input wire logic resetn,
    // Paged command port
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_page,
    input wire logic [15:0] cmd_wdata,
    output logic rsp_valid_r,
    output logic rsp_err_r,
    output logic [15:0] rsp_rdata_r,
    // Rail control and fault sources
    input wire logic ctrl_pin,
    input wire logic bias_ok,
    input wire logic [1:0] operation_on,
    input wire logic [1:0] oc_detect,
    input wire logic [1:0] uc_detect,
    input wire logic [1:0] other_fault_shutdown,
    input wire logic [1:0][15:0] stage_temp,
    input wire logic clear_faults,
    // Outputs
    output logic [1:0] rail_enable_r,
    output logic [1:0] oc_flag_r,
    output logic [1:0] uc_flag_r,
    output logic [1:0] ot_flag_r,
    output logic [1:0] ot_active_r,
    output logic fault_alert_out_n_r
);
    localparam int NR = oc_ot_pkg::NUM_RAILS;
    localparam int CW = oc_ot_pkg::CNT_W;

    // Delay code to cycles; zero code still costs one wait cycle
    function automatic logic [CW-1:0] retry_cycles(input logic [2:0] code);
        logic [CW-1:0] res;
        res = oc_ot_pkg::CNT_ZERO;
        if (code == oc_ot_pkg::DELAY_LONG) begin
            res = CW'(RETRY_LONG_CYC);
        end else if (code != oc_ot_pkg::DELAY_ZERO) begin
            res = CW'(RETRY_STEP_CYC * int'(code));
        end
        return res;
    endfunction : retry_cycles

    // Pin synchronisers, first stage read only by second
    logic [1:0] pin_meta_r;
    logic [1:0] pin_sync_r;
    // Per-page registers
    logic [7:0] oc_resp_r [NR];
    logic [7:0] oc_resp_nxt [NR];
    logic [15:0] ot_limit_r [NR];
    logic [15:0] ot_limit_nxt [NR];
    // Rail supervision
    oc_ot_pkg::rail_state_e state_r [NR];
    oc_ot_pkg::rail_state_e state_nxt [NR];
    logic [CW-1:0] cnt_r [NR];
    logic [CW-1:0] cnt_nxt [NR];
    // Next values of outputs
    logic [1:0] rail_enable_nxt;
    logic [1:0] oc_flag_nxt;
    logic [1:0] uc_flag_nxt;
    logic [1:0] ot_flag_nxt;
    logic [1:0] ot_active_nxt;
    logic alert_n_nxt;
    logic rsp_valid_nxt;
    logic rsp_err_nxt;
    logic [15:0] rsp_rdata_nxt;
    // Rail may run: pin, operation command and bias all agree
    logic [1:0] run_req;

    assign run_req = {2{pin_sync_r[0] & pin_sync_r[1]}} & operation_on;

    // Next-state computation for every register group except the pin synchronisers
    always_comb begin
        logic fault;
        logic over;
        logic cleared;
        logic [1:0] resp;
        logic [2:0] retry;
        fault = 1'b0;
        over = 1'b0;
        cleared = 1'b0;
        resp = 2'h0;
        retry = 3'h0;
        oc_resp_nxt = oc_resp_r;
        ot_limit_nxt = ot_limit_r;
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        rsp_valid_nxt = 1'b0;
        rsp_err_nxt = 1'b0;
        rsp_rdata_nxt = rsp_rdata_r;
        for (int i = 0; i < NR; i++) begin
            resp = oc_resp_r[i][oc_ot_pkg::RESP_HI:oc_ot_pkg::RESP_LO];
            retry = oc_resp_r[i][oc_ot_pkg::RETRY_HI:oc_ot_pkg::RETRY_LO];
            // either current fault uses one response
            fault = (oc_detect[i] | uc_detect[i]) & (state_r[i] == oc_ot_pkg::ST_RUN);
            // sticky flags, a new fault beats a clear
            oc_flag_nxt[i] = (oc_flag_r[i] & ~clear_faults) | (oc_detect[i] & (state_r[i] == oc_ot_pkg::ST_RUN));
            uc_flag_nxt[i] = (uc_flag_r[i] & ~clear_faults) | (uc_detect[i] & (state_r[i] == oc_ot_pkg::ST_RUN));
            over = stage_temp[i] > ot_limit_r[i];
            cleared = ({1'b0, stage_temp[i]} + oc_ot_pkg::OT_HYST) <= {1'b0, ot_limit_r[i]};
            ot_active_nxt[i] = over | (ot_active_r[i] & ~cleared);
            ot_flag_nxt[i] = (ot_flag_r[i] & ~clear_faults) | over;
            case (state_r[i])
                oc_ot_pkg::ST_OFF: begin
                    if (run_req[i] && !other_fault_shutdown[i]) begin
                        state_nxt[i] = oc_ot_pkg::ST_RUN;
                    end
                end
                oc_ot_pkg::ST_RUN: begin
                    if (!run_req[i]) begin
                        state_nxt[i] = oc_ot_pkg::ST_OFF;
                    end else if (other_fault_shutdown[i]) begin
                        state_nxt[i] = oc_ot_pkg::ST_LATCHED;
                    // code 00 rides through the fault
                    end else if (fault && resp != oc_ot_pkg::RESP_CONTINUE) begin
                        if (resp == oc_ot_pkg::RESP_SHUTDOWN && retry == oc_ot_pkg::RETRY_CONT) begin
                            state_nxt[i] = oc_ot_pkg::ST_WAIT;
                            cnt_nxt[i] = retry_cycles(oc_resp_r[i][oc_ot_pkg::DELAY_HI:oc_ot_pkg::DELAY_LO]);
                        end else begin
                            state_nxt[i] = oc_ot_pkg::ST_LATCHED;
                        end
                    end
                end
                oc_ot_pkg::ST_LATCHED: begin
                    // restart needs the rail commanded off first
                    if (!run_req[i]) begin
                        state_nxt[i] = oc_ot_pkg::ST_OFF;
                    end
                end
                oc_ot_pkg::ST_WAIT: begin
                    // stop retrying on off, bias loss or other fault
                    if (!run_req[i]) begin
                        state_nxt[i] = oc_ot_pkg::ST_OFF;
                    end else if (other_fault_shutdown[i]) begin
                        state_nxt[i] = oc_ot_pkg::ST_LATCHED;
                    end else if (cnt_r[i] == oc_ot_pkg::CNT_ZERO) begin
                        state_nxt[i] = oc_ot_pkg::ST_RUN;
                    end else begin
                        cnt_nxt[i] = cnt_r[i] - CW'(1);
                    end
                end
                default: begin
                    state_nxt[i] = oc_ot_pkg::ST_OFF;
                end
            endcase
            rail_enable_nxt[i] = (state_nxt[i] == oc_ot_pkg::ST_RUN);
        end
        // alert low while any current fault flag stands
        alert_n_nxt = ~(|oc_flag_nxt | |uc_flag_nxt);
        // Command access, answered one cycle later
        if (cmd_valid) begin
            rsp_valid_nxt = 1'b1;
            if (cmd_code == oc_ot_pkg::CMD_OC_RESP) begin
                if (cmd_write) begin
                    oc_resp_nxt[cmd_page] = cmd_wdata[7:0];
                end
                rsp_rdata_nxt = {8'h00, oc_resp_r[cmd_page]};
            end else if (cmd_code == oc_ot_pkg::CMD_OT_LIMIT) begin
                if (cmd_write && cmd_wdata > oc_ot_pkg::OT_LIMIT_MAX) begin
                    rsp_err_nxt = 1'b1;
                end else if (cmd_write) begin
                    ot_limit_nxt[cmd_page] = cmd_wdata;
                end
                rsp_rdata_nxt = ot_limit_r[cmd_page];
            end else begin
                // Unknown command answers with error and zero
                rsp_err_nxt = 1'b1;
                rsp_rdata_nxt = 16'h0000;
            end
        end
    end

    // Registers only; synchronous active-low reset
    always_ff @(posedge core_clk) begin
        pin_meta_r <= {bias_ok, ctrl_pin};
        pin_sync_r <= pin_meta_r;
        if (!resetn) begin
            for (int i = 0; i < NR; i++) begin
                oc_resp_r[i] <= oc_ot_pkg::OC_RESP_RESET;
                ot_limit_r[i] <= oc_ot_pkg::OT_LIMIT_RESET;
                state_r[i] <= oc_ot_pkg::ST_OFF;
                cnt_r[i] <= oc_ot_pkg::CNT_ZERO;
            end
            rail_enable_r <= 2'h0;
            oc_flag_r <= 2'h0;
            uc_flag_r <= 2'h0;
            ot_flag_r <= 2'h0;
            ot_active_r <= 2'h0;
            fault_alert_out_n_r <= 1'b1;
            rsp_valid_r <= 1'b0;
            rsp_err_r <= 1'b0;
            rsp_rdata_r <= 16'h0000;
        end else begin
            oc_resp_r <= oc_resp_nxt;
            ot_limit_r <= ot_limit_nxt;
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            rail_enable_r <= rail_enable_nxt;
            oc_flag_r <= oc_flag_nxt;
            uc_flag_r <= uc_flag_nxt;
            ot_flag_r <= ot_flag_nxt;
            ot_active_r <= ot_active_nxt;
            fault_alert_out_n_r <= alert_n_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rsp_err_r <= rsp_err_nxt;
            rsp_rdata_r <= rsp_rdata_nxt;
        end
    end

    // Checks on rail 0, plus the threshold range on both rails; rail 1 shares the same code
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    logic run0;
    logic [1:0] resp0;
    logic [2:0] retry0;
    assign run0 = state_r[0] == oc_ot_pkg::ST_RUN && run_req[0] && !other_fault_shutdown[0];
    assign resp0 = oc_resp_r[0][oc_ot_pkg::RESP_HI:oc_ot_pkg::RESP_LO];
    assign retry0 = oc_resp_r[0][oc_ot_pkg::RETRY_HI:oc_ot_pkg::RETRY_LO];

    property p_uc_latch;
        run0 && uc_detect[0] && resp0 == oc_ot_pkg::RESP_SHUTDOWN && retry0 == oc_ot_pkg::RETRY_LATCH
            |=> state_r[0] == oc_ot_pkg::ST_LATCHED && !rail_enable_r[0];
    endproperty
    a_uc_latch: assert property (p_uc_latch) else $error("undercurrent did not latch rail");
    property p_continue;
        run0 && oc_detect[0] && resp0 == oc_ot_pkg::RESP_CONTINUE |=> rail_enable_r[0];
    endproperty
    a_continue: assert property (p_continue) else $error("rail dropped on continue code");
    property p_alert;
        run0 && oc_detect[0] |=> oc_flag_r[0] ##1 !fault_alert_out_n_r;
    endproperty
    a_alert: assert property (p_alert) else $error("fault did not raise flag and alert");
    property p_latched_holds;
        state_r[0] == oc_ot_pkg::ST_LATCHED && run_req[0] |=> !rail_enable_r[0];
    endproperty
    a_latched_holds: assert property (p_latched_holds) else $error("latched rail re-enabled");
    property p_retry_restart;
        state_r[0] == oc_ot_pkg::ST_WAIT && cnt_r[0] == oc_ot_pkg::CNT_ZERO && run_req[0]
            && !other_fault_shutdown[0] |=> rail_enable_r[0];
    endproperty
    a_retry_restart: assert property (p_retry_restart) else $error("retry did not restart");
    property p_retry_stop;
        state_r[0] == oc_ot_pkg::ST_WAIT && !run_req[0]
            |=> state_r[0] == oc_ot_pkg::ST_OFF ##1 state_r[0] != oc_ot_pkg::ST_WAIT;
    endproperty
    a_retry_stop: assert property (p_retry_stop) else $error("retry continued after off");
    property p_delay_load;
        run0 && oc_detect[0] && resp0 == oc_ot_pkg::RESP_SHUTDOWN && retry0 == oc_ot_pkg::RETRY_CONT
            |=> cnt_r[0] == retry_cycles($past(oc_resp_r[0][oc_ot_pkg::DELAY_HI:oc_ot_pkg::DELAY_LO]));
    endproperty
    a_delay_load: assert property (p_delay_load) else $error("retry delay wrong");
    property p_reset_vals;
        disable iff (1'b0) !resetn |=> oc_resp_r[0] == oc_ot_pkg::OC_RESP_RESET
            && ot_limit_r[0] == oc_ot_pkg::OT_LIMIT_RESET;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
    property p_limit_range;
        ot_limit_r[0] <= oc_ot_pkg::OT_LIMIT_MAX && ot_limit_r[1] <= oc_ot_pkg::OT_LIMIT_MAX;
    endproperty
    a_limit_range: assert property (p_limit_range) else $error("threshold above range");
    property p_ot_hold;
        ot_active_r[0] && ({1'b0, stage_temp[0]} + oc_ot_pkg::OT_HYST) > {1'b0, ot_limit_r[0]}
            |=> ot_active_r[0];
    endproperty
    a_ot_hold: assert property (p_ot_hold) else $error("over-temperature cleared early");
    property p_ot_set;
        stage_temp[0] > ot_limit_r[0] |=> ot_active_r[0] && ot_flag_r[0];
    endproperty
    a_ot_set: assert property (p_ot_set) else $error("over-temperature not flagged");
    c_retry: cover property (state_r[0] == oc_ot_pkg::ST_WAIT ##1 state_r[0] == oc_ot_pkg::ST_RUN);
    c_latch: cover property (state_r[0] == oc_ot_pkg::ST_RUN ##1 state_r[0] == oc_ot_pkg::ST_LATCHED);
    c_ot: cover property (ot_active_r[0] ##1 !ot_active_r[0]);
endmodule : oc_fault_response_ot_limit

//--- cmd_host.sv
/*
 * Host model for the paged command port: issues one command at a time
 * as a one-cycle request and collects the registered answer.
 * Assumes the block answers one cycle after taking the request.
 */
`timescale 1ns/1ps
module cmd_host (
    input wire logic core_clk,
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_code,
    output logic cmd_page,
    output logic [15:0] cmd_wdata,
    input wire logic rsp_valid_r,
    input wire logic rsp_err_r,
    input wire logic [15:0] rsp_rdata_r
);
    // Idle port at time zero
    initial begin
        cmd_valid = 1'h0;
        cmd_write = 1'h0;
        cmd_code = 8'h00;
        cmd_page = 1'h0;
        cmd_wdata = 16'h0000;
    end

    // One command; on release code and data are inverted so stale values never look valid
    task automatic access(input logic wr, input logic [7:0] code, input logic pg, input logic [15:0] wd,
                          output logic [15:0] rd, output logic er);
        int n;
        n = 0;
        @(negedge core_clk);
        cmd_valid = 1'h1;
        cmd_write = wr;
        cmd_code = code;
        cmd_page = pg;
        cmd_wdata = wd;
        @(negedge core_clk);
        cmd_valid = 1'h0;
        cmd_code = ~code;
        cmd_wdata = ~wd;
        // Bounded wait for the answer pulse
        while (rsp_valid_r !== 1'h1 && n < 4) begin
            n++;
            @(negedge core_clk);
        end
        if (rsp_valid_r === 1'h1) begin
            rd = rsp_rdata_r;
            er = rsp_err_r;
        end else begin
            // No answer in time: unknowns make the caller's compare fail
            rd = 16'hXXXX;
            er = 1'hX;
        end
    endtask : access
endmodule : cmd_host

//--- tb.sv
/*
 * Self-checking bench: register defaults, paged access, refusals,
 * overcurrent responses, undercurrent retry timing, retry stop, over-temperature.
 * Assumes shortened retry counts of 4 and 30 cycles.
 */
`timescale 1ns/1ps
module tb;
    logic core_clk = 1'h0, resetn = 1'h0, ctrl_pin = 1'h0, bias_ok = 1'h0, clear_faults = 1'h0;
    logic [1:0] operation_on = 2'h0, oc_detect = 2'h0, uc_detect = 2'h0, other_fault_shutdown = 2'h0;
    logic [1:0][15:0] stage_temp = '0;
    logic cmd_valid, cmd_write, cmd_page, rsp_valid_r, rsp_err_r, alert_n;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata, rsp_rdata_r;
    logic [1:0] rail_en, oc_flag, uc_flag, ot_flag, ot_act;
    int err_total = 0, comparisons = 0, low;
    int delay_code[4] = '{0, 1, 6, 7};
    int delay_cyc[4] = '{0, 4, 24, 30};

    // Free-running 50 MHz clock
    always #10 core_clk = ~core_clk;

    cmd_host u_host (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
        .cmd_page(cmd_page), .cmd_wdata(cmd_wdata), .rsp_valid_r(rsp_valid_r), .rsp_err_r(rsp_err_r),
        .rsp_rdata_r(rsp_rdata_r));

    // Short retry counts keep the run brief
    oc_fault_response_ot_limit #(.RETRY_STEP_CYC(4), .RETRY_LONG_CYC(30)) u_dut (.core_clk(core_clk),
        .resetn(resetn), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_page(cmd_page),
        .cmd_wdata(cmd_wdata), .rsp_valid_r(rsp_valid_r), .rsp_err_r(rsp_err_r), .rsp_rdata_r(rsp_rdata_r),
        .ctrl_pin(ctrl_pin), .bias_ok(bias_ok), .operation_on(operation_on), .oc_detect(oc_detect),
        .uc_detect(uc_detect), .other_fault_shutdown(other_fault_shutdown), .stage_temp(stage_temp),
        .clear_faults(clear_faults), .rail_enable_r(rail_en), .oc_flag_r(oc_flag), .uc_flag_r(uc_flag),
        .ot_flag_r(ot_flag), .ot_active_r(ot_act), .fault_alert_out_n_r(alert_n));

    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Command with expected error flag; read data is checked on reads only
    task automatic op(input logic w, input logic [7:0] c, input logic p, input logic [15:0] d, input logic e);
        logic [15:0] r;
        logic er;
        u_host.access(w, c, p, d, r, er);
        chk({15'h0000, er}, {15'h0000, e});
        if (!w) begin
            chk(r, d);
        end
    endtask : op

    task automatic idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask : idle

    // One-cycle fault on rail 0, taken at the rising edge in between
    task automatic kick(input logic uc);
        @(negedge core_clk);
        if (uc) begin
            uc_detect[0] = 1'h1;
        end else begin
            oc_detect[0] = 1'h1;
        end
        @(negedge core_clk);
        oc_detect[0] = 1'h0;
        uc_detect[0] = 1'h0;
    endtask : kick

    // Fault, then count cycles the rail stays off (100 = latched)
    task automatic hit(input logic uc);
        kick(uc);
        low = 0;
        while (rail_en[0] === 1'h0 && low < 100) begin
            low++;
            @(negedge core_clk);
        end
    endtask : hit

    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    // Watchdog sized well above the expected run length
    initial begin
        #200000;
        err_total++;
        results();
    end

    // Main sequence
    initial begin
        idle(5);
        resetn = 1'h1;
        op(1'h0, 8'h47, 1'h0, 16'h00C4, 1'h0);
        op(1'h0, 8'h47, 1'h1, 16'h00C4, 1'h0);
        op(1'h0, 8'h4F, 1'h0, 16'h007D, 1'h0);
        op(1'h1, 8'h4F, 1'h1, 16'h0096, 1'h0);
        op(1'h1, 8'h4F, 1'h1, 16'h0097, 1'h1);
        op(1'h0, 8'h4F, 1'h1, 16'h0096, 1'h0);
        op(1'h0, 8'h4F, 1'h0, 16'h007D, 1'h0);
        op(1'h0, 8'h20, 1'h0, 16'h0000, 1'h1);
        // Bring both rails up
        ctrl_pin = 1'h1;
        bias_ok = 1'h1;
        operation_on = 2'h3;
        idle(6);
        chk({14'h0000, rail_en}, 16'h0003);
        // Default response latches off
        hit(1'h0);
        chk(low[15:0], 16'h0064);
        chk({14'h0000, alert_n, oc_flag[0]}, 16'h0001);
        clear_faults = 1'h1;
        idle(1);
        clear_faults = 1'h0;
        idle(3);
        chk({15'h0000, alert_n}, 16'h0001);
        operation_on[0] = 1'h0;
        idle(3);
        operation_on[0] = 1'h1;
        idle(6);
        // Continue code keeps the rail up but still flags
        op(1'h1, 8'h47, 1'h0, 16'h0000, 1'h0);
        hit(1'h0);
        chk(low[15:0], 16'h0000);
        chk({15'h0000, oc_flag[0]}, 16'h0001);
        // Undercurrent follows the same retry timing for every delay band
        for (int i = 0; i < 4; i++) begin
            op(1'h1, 8'h47, 1'h0, 16'h00F8 | delay_code[i][15:0], 1'h0);
            hit(1'h1);
            chk(low[15:0], delay_cyc[i][15:0] + 16'h0001);
        end
        chk({15'h0000, uc_flag[0]}, 16'h0001);
        // Off command during the wait ends retrying: restart follows the command, not the delay
        kick(1'h0);
        operation_on[0] = 1'h0;
        idle(2);
        operation_on[0] = 1'h1;
        idle(5);
        chk({15'h0000, rail_en[0]}, 16'h0001);
        // Another fault during the wait latches the rail past the retry delay
        kick(1'h0);
        other_fault_shutdown[0] = 1'h1;
        idle(1);
        other_fault_shutdown[0] = 1'h0;
        idle(40);
        chk({15'h0000, rail_en[0]}, 16'h0000);
        operation_on[0] = 1'h0;
        idle(3);
        operation_on[0] = 1'h1;
        idle(6);
        chk({15'h0000, rail_en[0]}, 16'h0001);
        // Over-temperature with hysteresis
        op(1'h1, 8'h4F, 1'h0, 16'h0050, 1'h0);
        stage_temp[0] = 16'h0051;
        idle(2);
        chk({14'h0000, ot_act[0], ot_flag[0]}, 16'h0003);
        stage_temp[0] = 16'h004C;
        idle(2);
        chk({15'h0000, ot_act[0]}, 16'h0001);
        stage_temp[0] = 16'h004B;
        idle(2);
        chk({15'h0000, ot_act[0]}, 16'h0000);
        // Page 1 keeps its own latch-off default and its own limit
        stage_temp[1] = 16'h0097;
        uc_detect[1] = 1'h1;
        idle(1);
        uc_detect[1] = 1'h0;
        idle(2);
        chk({11'h000, rail_en[1], oc_flag[1], uc_flag[1], ot_flag[1], ot_act[1]}, 16'h0007);
        results();
    end
endmodule : tb
